// *** common/ckpm_pkg.sv ***
// Types shared by the clock controller design.
`default_nettype none
package ckpm_pkg;
  // Main clock measurement sequence, one-hot.
  typedef enum logic [2:0] {
    MEAS_IDLE  = 3'b001,
    MEAS_COUNT = 3'b010,
    MEAS_DONE  = 3'b100
  } ckpm_meas_t;

  // Clock source codes.
  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_RSVD = 2'b10,
    SRC_PLL  = 2'b11
  } ckpm_src_t;
endpackage : ckpm_pkg
`default_nettype wire

// *** common/ckpm_regs.svh ***
// Register offsets, field positions, reset values and counts of the clock controller.
`ifndef CKPM_REGS_SVH
`define CKPM_REGS_SVH

`define CKPM_OFF_OSC_CTRL    8'h20
`define CKPM_OFF_MAIN_MEAS   8'h24
`define CKPM_OFF_PLL_CFG     8'h2c
`define CKPM_OFF_MCK_CFG     8'h30
`define CKPM_OFF_PCK0        8'h40
`define CKPM_OFF_IRQ_SET     8'h60
`define CKPM_OFF_IRQ_CLR     8'h64
`define CKPM_OFF_STATUS      8'h68
`define CKPM_OFF_IRQ_VIEW    8'h6c

`define CKPM_OSC_EN_BIT      0
`define CKPM_OSC_CNT_LSB     8
`define CKPM_OSC_CNT_W       8
`define CKPM_OSC_MULT_SHIFT  3
`define CKPM_MEAS_WINDOW     5'h10
`define CKPM_MEAS_VALID_BIT  16
`define CKPM_PLL_DIV_LSB     0
`define CKPM_PLL_CNT_LSB     8
`define CKPM_PLL_CNT_W       6
`define CKPM_PLL_MUL_LSB     16
`define CKPM_PLL_MUL_W       11
`define CKPM_PLL_USB_LSB     28
`define CKPM_CSS_LSB         0
`define CKPM_CLOCK_SCALER_RATIO_LSB        2
`define CKPM_CLOCK_SCALER_RATIO_MAX        3'h6
`define CKPM_ST_MOSC         0
`define CKPM_ST_LOCK         2
`define CKPM_ST_MCK          3
`define CKPM_ST_PCK0         8
`define CKPM_STATUS_RESET    12'h008
`define CKPM_STATUS_USED     12'hf0d

`endif

// *** rtl/ckpm_ctrl.sv ***
// Clock generator and power manager control, status and divider logic with an APB slave.
//
// Chosen here: the register offsets and register access over APB.
`include "ckpm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ckpm_ctrl #(
  parameter int NUM_PCK = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        slow_clk_in,
  input  wire logic        main_clk_in,
  input  wire logic        pll_clk_in,
  output var  logic        main_osc_en,
  output var  logic        pll_enable,
  output var  logic [10:0] pll_feedback_factor,
  output var  logic        pll_ref_tick,
  output var  logic        usb_clk_tick,
  output var  logic        mck_tick,
  output var  logic [3:0]  pck_tick,
  output var  logic        irq
);

  // Refuse a count of programmable outputs that the four-entry storage cannot serve.
  if (NUM_PCK < 1 || NUM_PCK > 4) begin : g_bad_num_pck
    $error("NUM_PCK must lie between 1 and 4.");
  end

  // Source select to source edge.
  function automatic logic src_edge(input logic [1:0] clock_source_sel, input logic s, input logic m, input logic p);
    case (clock_source_sel)
      2'b00:   src_edge = s;
      2'b01:   src_edge = m;
      2'b11:   src_edge = p;
      default: src_edge = 1'b0;
    endcase
  endfunction : src_edge

  // Prescaler terminal count: divide by two to the code, reserved code never fires.
  function automatic logic clock_scaler_ratio_hit(input logic [5:0] cnt, input logic [2:0] code);
    logic [5:0] lim;
    lim = 6'(7'h01 << code) - 6'h01;
    clock_scaler_ratio_hit = (code <= `CKPM_CLOCK_SCALER_RATIO_MAX) && (cnt >= lim);
  endfunction : clock_scaler_ratio_hit

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_last;
  logic       slow_e;
  logic       main_e;
  logic       pll_e;

  // Two flops per pin input; the third stage feeds the edge detectors only.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_a    <= 3'h0;
      sync_b    <= 3'h0;
      sync_last <= 3'h0;
    end else begin
      sync_a    <= {pll_clk_in, main_clk_in, slow_clk_in};
      sync_b    <= sync_a;
      sync_last <= sync_b;
    end
  end

  assign slow_e = sync_b[0] & ~sync_last[0];
  assign main_e = sync_b[1] & ~sync_last[1];
  assign pll_e  = sync_b[2] & ~sync_last[2];

  ////////////////////////////////////////////////////////////////////////////
  // APB register file.

  logic        wr_acc;
  logic        rd_setup;
  logic [15:0] osc_ctrl;
  logic [31:0] pll_cfg;
  logic [4:0]  mck_cfg;
  logic [4:0]  pck_cfg [4];
  logic [11:0] irq_en;
  logic [11:0] status;
  logic [11:0] irq_evt;
  logic [15:0] main_freq_count;
  logic        main_count_valid;
  logic        pll_wr;
  logic        mck_wr;
  logic [3:0]  pck_wr;
  logic        st_rd;

  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pll_wr   = wr_acc && paddr == `CKPM_OFF_PLL_CFG;
  assign mck_wr   = wr_acc && paddr == `CKPM_OFF_MCK_CFG;
  assign st_rd    = psel & penable & ~pwrite && paddr == `CKPM_OFF_STATUS;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pck_wr[i] = wr_acc && (i < NUM_PCK) && paddr == (`CKPM_OFF_PCK0 + 8'(4 * i));
    end
  end

  // Writable configuration registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_ctrl <= 16'h0000;
      pll_cfg  <= 32'h0000_0000;
      mck_cfg  <= 5'h00;
      for (int i = 0; i < 4; i++) begin
        pck_cfg[i] <= 5'h00;
      end
    end else begin
      if (wr_acc && paddr == `CKPM_OFF_OSC_CTRL) begin
        osc_ctrl <= {pwdata[15:8], 7'h00, pwdata[0]};
      end
      if (pll_wr) begin
        pll_cfg <= {2'h0, pwdata[29:28], 1'b0, pwdata[26:0]};
      end
      if (mck_wr) begin
        mck_cfg <= pwdata[4:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (pck_wr[i]) begin
          pck_cfg[i] <= pwdata[4:0];
        end
      end
    end
  end

  // Interrupt enables: one bits set or clear, zero bits leave alone.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_en <= 12'h000;
    end else if (wr_acc && paddr == `CKPM_OFF_IRQ_SET) begin
      irq_en <= irq_en | (pwdata[11:0] & `CKPM_STATUS_USED);
    end else if (wr_acc && paddr == `CKPM_OFF_IRQ_CLR) begin
      irq_en <= irq_en & ~pwdata[11:0];
    end
  end

  // Read data and error are captured in the setup cycle and held through access.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == `CKPM_OFF_OSC_CTRL) begin
        prdata <= rd_setup ? {16'h0000, osc_ctrl} : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_MAIN_MEAS) begin
        prdata <= rd_setup ? {15'h0000, main_count_valid, main_freq_count} : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_PLL_CFG) begin
        prdata <= rd_setup ? pll_cfg : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_MCK_CFG) begin
        prdata <= rd_setup ? {27'h0, mck_cfg} : 32'h0000_0000;
      end else if (paddr >= `CKPM_OFF_PCK0 && paddr < `CKPM_OFF_PCK0 + 8'(4 * NUM_PCK) && paddr[1:0] == 2'b00) begin
        prdata <= rd_setup ? {27'h0, pck_cfg[paddr[3:2]]} : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_STATUS) begin
        prdata <= rd_setup ? {20'h0, status} : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_IRQ_VIEW) begin
        prdata <= rd_setup ? {20'h0, ~irq_en & `CKPM_STATUS_USED} : 32'h0000_0000;
      end else if (paddr == `CKPM_OFF_IRQ_SET || paddr == `CKPM_OFF_IRQ_CLR) begin
        pslverr <= ~pwrite;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main oscillator startup.

  logic [10:0] osc_cnt;
  logic        osc_stable;

  assign main_osc_en = osc_ctrl[`CKPM_OSC_EN_BIT];

  // Count startup count times eight slow edges after enable; disable restarts it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_cnt    <= 11'h000;
      osc_stable <= 1'b0;
    end else if (!main_osc_en) begin
      osc_cnt    <= 11'h000;
      osc_stable <= 1'b0;
    end else if (osc_cnt >= {osc_ctrl[15:8], 3'h0}) begin
      osc_stable <= 1'b1;
    end else if (slow_e) begin
      osc_cnt <= osc_cnt + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main clock frequency measurement.

  ckpm_pkg::ckpm_meas_t meas_st;
  logic [4:0]           win_cnt;
  logic [15:0]          edge_cnt;

  // Sixteen slow periods are opened and closed on slow edges; main edges counted between.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meas_st          <= ckpm_pkg::MEAS_IDLE;
      win_cnt          <= 5'h00;
      edge_cnt         <= 16'h0000;
      main_freq_count  <= 16'h0000;
      main_count_valid <= 1'b0;
    end else if (!osc_stable) begin
      meas_st          <= ckpm_pkg::MEAS_IDLE;
      main_count_valid <= 1'b0;
    end else begin
      case (meas_st)
        ckpm_pkg::MEAS_IDLE: begin
          if (slow_e) begin
            win_cnt  <= 5'h00;
            edge_cnt <= 16'h0000;
            meas_st  <= ckpm_pkg::MEAS_COUNT;
          end
        end
        ckpm_pkg::MEAS_COUNT: begin
          if (main_e) begin
            edge_cnt <= edge_cnt + 16'h0001;
          end
          if (slow_e) begin
            win_cnt <= win_cnt + 5'h01;
            if (win_cnt + 5'h01 == `CKPM_MEAS_WINDOW) begin
              meas_st <= ckpm_pkg::MEAS_DONE;
            end
          end
        end
        ckpm_pkg::MEAS_DONE: begin
          main_freq_count  <= edge_cnt;
          main_count_valid <= 1'b1;
        end
        default: meas_st <= ckpm_pkg::MEAS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL control: input divider, lock wait and USB divider.

  logic [7:0] ref_cnt;
  logic [5:0] settle_cnt;
  logic       pll_locked;
  logic [1:0] usb_cnt;

  assign pll_feedback_factor = pll_cfg[`CKPM_PLL_MUL_LSB +: `CKPM_PLL_MUL_W];
  assign pll_enable = (pll_feedback_factor != 11'h000) && (pll_cfg[7:0] != 8'h00);

  // Reference tick from the main clock divided by the prescale field.
  always_ff @(posedge sys_clk) begin
    if (srst || pll_wr) begin
      ref_cnt      <= 8'h00;
      pll_ref_tick <= 1'b0;
    end else begin
      pll_ref_tick <= 1'b0;
      if (main_e && pll_cfg[7:0] != 8'h00) begin
        if (ref_cnt + 8'h01 >= pll_cfg[7:0]) begin
          ref_cnt      <= 8'h00;
          pll_ref_tick <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 8'h01;
        end
      end
    end
  end

  // Lock waits the settle count in slow edges after every configuration write.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      settle_cnt <= 6'h00;
      pll_locked <= 1'b0;
    end else if (pll_wr) begin
      settle_cnt <= pwdata[`CKPM_PLL_CNT_LSB +: `CKPM_PLL_CNT_W];
      pll_locked <= 1'b0;
    end else if (!pll_enable) begin
      pll_locked <= 1'b0;
    end else if (settle_cnt == 6'h00) begin
      pll_locked <= 1'b1;
    end else if (slow_e) begin
      settle_cnt <= settle_cnt - 6'h01;
    end
  end

  // USB tick passes, halves or quarters the PLL edges; the reserved code stays silent.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      usb_cnt      <= 2'h0;
      usb_clk_tick <= 1'b0;
    end else begin
      usb_clk_tick <= 1'b0;
      if (pll_e && pll_locked) begin
        usb_cnt <= usb_cnt + 2'h1;
        case (pll_cfg[29:28])
          2'b00:   usb_clk_tick <= 1'b1;
          2'b01:   usb_clk_tick <= usb_cnt[0];
          2'b10:   usb_clk_tick <= &usb_cnt;
          default: usb_clk_tick <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master and programmable clock prescalers with ready flags.

  logic [5:0] mck_cnt;
  logic       mck_ok;
  logic       mck_src;
  logic [5:0] pck_cnt [4];
  logic [3:0] pck_ok;

  assign mck_src = src_edge(mck_cfg[1:0], slow_e, main_e, pll_e & pll_locked);

  // Master tick every two to the code source edges; ready returns on the first tick.
  always_ff @(posedge sys_clk) begin
    if (srst || mck_wr) begin
      mck_cnt  <= 6'h00;
      mck_tick <= 1'b0;
      mck_ok   <= srst;
    end else begin
      mck_tick <= 1'b0;
      if (mck_src) begin
        if (clock_scaler_ratio_hit(mck_cnt, mck_cfg[4:2])) begin
          mck_cnt  <= 6'h00;
          mck_tick <= 1'b1;
          mck_ok   <= 1'b1;
        end else begin
          mck_cnt <= mck_cnt + 6'h01;
        end
      end
    end
  end

  // Each programmable output runs its own select and prescaler.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst || pck_wr[i] || i >= NUM_PCK) begin
        pck_cnt[i]  <= 6'h00;
        pck_tick[i] <= 1'b0;
        pck_ok[i]   <= 1'b0;
      end else begin
        pck_tick[i] <= 1'b0;
        if (src_edge(pck_cfg[i][1:0], slow_e, main_e, pll_e & pll_locked)) begin
          if (clock_scaler_ratio_hit(pck_cnt[i], pck_cfg[i][4:2])) begin
            pck_cnt[i]  <= 6'h00;
            pck_tick[i] <= 1'b1;
            pck_ok[i]   <= 1'b1;
          end else begin
            pck_cnt[i] <= pck_cnt[i] + 6'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, sticky events and interrupt.

  assign status = {pck_ok, 4'h0, mck_ok, pll_locked, 1'b0, osc_stable};

  // Events stick while set; a status read clears them but a standing level sets again.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_evt <= 12'h000;
    end else begin
      irq_evt <= (st_rd ? 12'h000 : irq_evt) | status;
    end
  end

  // Single level interrupt from enabled events.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_evt | status) & irq_en);
    end
  end

endmodule : ckpm_ctrl
`default_nettype wire

// *** sim/ckpm_ctrl_chk.sv ***
// Concurrent checks on the ports of the clock controller.
`timescale 1ns/1ps
`default_nettype none
`include "ckpm_regs.svh"

module ckpm_ctrl_chk #(
  parameter int NUM_PCK = 4
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        slow_clk_in,
  input wire logic        main_clk_in,
  input wire logic        pll_clk_in,
  input wire logic        main_osc_en,
  input wire logic        pll_enable,
  input wire logic [10:0] pll_feedback_factor,
  input wire logic        pll_ref_tick,
  input wire logic        usb_clk_tick,
  input wire logic        mck_tick,
  input wire logic [3:0]  pck_tick,
  input wire logic        irq
);
  // All checks share the system clock and are idle during reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // The interrupt line leaves reset low.
  chk_irq_after_reset:
    assert property ($past(srst) |-> !irq) else $error("irq high right after reset");
  // A zero feedback factor keeps the loop switched off.
  chk_pll_off_zero:
    assert property (pll_feedback_factor == 11'h000 |-> !pll_enable) else $error("pll enabled with zero factor");
  // A switched off loop loses lock, so the USB tick falls silent one edge later.
  chk_usb_off_idle:
    assert property (!pll_enable |=> !usb_clk_tick) else $error("usb tick while pll is off");
  // Source edges are at least four cycles apart, so divided ticks are too.
  chk_ref_tick_gap:
    assert property (pll_ref_tick |=> !pll_ref_tick [*3]) else $error("reference tick too close");
  chk_usb_tick_gap:
    assert property (usb_clk_tick |=> !usb_clk_tick [*3]) else $error("usb tick too close");
  // A config write may switch to a source whose next edge comes early, so that case is left out.
  chk_mck_tick_gap:
    assert property (mck_tick && !(psel && pwrite && paddr == `CKPM_OFF_MCK_CFG) |=> !mck_tick [*3])
      else $error("master tick too close");
  chk_pck_tick_pulse:
    assert property (|pck_tick |=> (pck_tick & $past(pck_tick)) == 4'h0) else $error("programmable tick held");
  // Clearing every enable drops the interrupt two edges later.
  chk_irq_clear_all:
    assert property (psel && penable && pwrite && paddr == `CKPM_OFF_IRQ_CLR && pwdata[11:0] == 12'hf0d
                     |-> ##2 !irq) else $error("irq still high after disable of all");
  // The mask view never shows bits outside the used set.
  chk_mask_unused:
    assert property (psel && !penable && !pwrite && paddr == `CKPM_OFF_IRQ_VIEW
                     |=> (prdata & 32'hfffff0f2) == 32'h0) else $error("mask view has unused bits set");
endmodule : ckpm_ctrl_chk

bind ckpm_ctrl ckpm_ctrl_chk #(.NUM_PCK(NUM_PCK)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_clk_in(slow_clk_in),
  .main_clk_in(main_clk_in), .pll_clk_in(pll_clk_in), .main_osc_en(main_osc_en), .pll_enable(pll_enable),
  .pll_feedback_factor(pll_feedback_factor), .pll_ref_tick(pll_ref_tick), .usb_clk_tick(usb_clk_tick),
  .mck_tick(mck_tick), .pck_tick(pck_tick), .irq(irq)
);
`default_nettype wire

// *** sim/ckpm_ctrl_tb.sv ***
// Self-checking testbench of the clock controller.
`timescale 1ns/1ps
`default_nettype none
`include "ckpm_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module ckpm_ctrl_tb;
  logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
  logic [7:0]  paddr = 8'h00, ph = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, main_osc_en, pll_enable, pll_ref_tick, usb_clk_tick, mck_tick, irq;
  logic        slow_clk_in = 1'b0, main_clk_in = 1'b0, pll_clk_in = 1'b0;
  logic [10:0] pll_feedback_factor;
  logic [3:0]  pck_tick;
  logic [1:0]  pph = 2'h0;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, c_ref = 0, c_usb = 0, c_mck = 0, d_ref, d_usb, d_mck;
  int          c_pck[4] = '{0, 0, 0, 0};
  int          d_pck[4];

  ckpm_ctrl #(.NUM_PCK(4)) dut (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_clk_in(slow_clk_in),
    .main_clk_in(main_clk_in), .pll_clk_in(pll_clk_in), .main_osc_en(main_osc_en), .pll_enable(pll_enable),
    .pll_feedback_factor(pll_feedback_factor), .pll_ref_tick(pll_ref_tick), .usb_clk_tick(usb_clk_tick),
    .mck_tick(mck_tick), .pck_tick(pck_tick), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The system clock runs at 10 MHz.
  initial forever #50 sys_clk = ~sys_clk;

  // Slow pin has a 16 cycle period, main 4 cycles, pll 6 cycles.
  always_ff @(posedge sys_clk) begin
    ph <= ph + 8'h01;
    slow_clk_in <= ph[3];
    main_clk_in <= ph[1];
    pph <= (pph == 2'h2) ? 2'h0 : pph + 2'h1;
    if (pph == 2'h2) pll_clk_in <= ~pll_clk_in;
  end

  // Ticks are counted here so scenarios can take differences over a window.
  always_ff @(posedge sys_clk) begin
    c_ref <= c_ref + int'(pll_ref_tick);
    c_usb <= c_usb + int'(usb_clk_tick);
    c_mck <= c_mck + int'(mck_tick);
    for (int i = 0; i < 4; i++) c_pck[i] <= c_pck[i] + int'(pck_tick[i]);
  end

  // A run that hangs is cut short and counted as a mismatch.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  // Counts ticks over a window of the given number of cycles.
  task automatic meas(input int n);
    int r0, u0, m0;
    int p0[4];
    r0 = c_ref;
    u0 = c_usb;
    m0 = c_mck;
    p0 = c_pck;
    repeat (n) @(posedge sys_clk);
    d_ref = c_ref - r0;
    d_usb = c_usb - u0;
    d_mck = c_mck - m0;
    for (int i = 0; i < 4; i++) d_pck[i] = c_pck[i] - p0[i];
  endtask : meas

  // Edge phase may shift a count by one, which is accepted.
  function automatic int near(input int e, input int g);
    return (g >= e - 1 && g <= e + 1) ? e : g;
  endfunction : near

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped access and interrupt enable handling.
  task automatic t_regs();
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("status_reset", 32'h00000008, rdat)
    xfer(1'b0, `CKPM_OFF_IRQ_VIEW, 32'h0);
    `CHK("mask_reset", 32'h00000f0d, rdat)
    `CHK("irq_reset", 1'b0, irq)
    xfer(1'b1, 8'h80, 32'hffffffff);
    xfer(1'b0, 8'h80, 32'h0);
    `CHK("unmapped_err", 1'b1, rerr)
    `CHK("unmapped_data", 32'h0, rdat)
    xfer(1'b0, `CKPM_OFF_IRQ_SET, 32'h0);
    `CHK("wo_read_err", 1'b1, rerr)
    xfer(1'b1, `CKPM_OFF_IRQ_SET, 32'h00000008);
    repeat (3) @(posedge sys_clk);
    `CHK("irq_enabled", 1'b1, irq)
    xfer(1'b1, `CKPM_OFF_IRQ_SET, 32'h0);
    xfer(1'b1, `CKPM_OFF_IRQ_CLR, 32'h0);
    xfer(1'b0, `CKPM_OFF_IRQ_VIEW, 32'h0);
    `CHK("mask_one_on", 32'h00000f05, rdat)
    xfer(1'b1, `CKPM_OFF_IRQ_CLR, 32'h00000f0d);
    @(posedge sys_clk);
    `CHK("irq_disabled", 1'b0, irq)
    xfer(1'b0, `CKPM_OFF_IRQ_VIEW, 32'h0);
    `CHK("mask_all_off", 32'h00000f0d, rdat)
  endtask : t_regs

  // Oscillator startup and main clock measurement.
  task automatic t_osc();
    xfer(1'b1, `CKPM_OFF_OSC_CTRL, 32'h00000201);
    `CHK("osc_enable", 1'b1, main_osc_en)
    xfer(1'b0, `CKPM_OFF_MAIN_MEAS, 32'h0);
    `CHK("count_early", 1'b0, rdat[16])
    repeat (192) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("osc_waiting", 1'b0, rdat[0])
    repeat (128) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("osc_stable", 1'b1, rdat[0])
    repeat (320) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_MAIN_MEAS, 32'h0);
    `CHK("count_valid", 1'b1, rdat[16])
    `CHK("main_count", 1'b1, rdat[15:0] >= 16'd63 && rdat[15:0] <= 16'd65)
    xfer(1'b1, `CKPM_OFF_OSC_CTRL, 32'h00000200);
    repeat (8) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("osc_off", 1'b0, rdat[0])
    xfer(1'b0, `CKPM_OFF_MAIN_MEAS, 32'h0);
    `CHK("count_off", 1'b0, rdat[16])
  endtask : t_osc

  // Lock timing, input divider, USB divider and feedback factor.
  task automatic t_pll();
    xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00040301);
    `CHK("pll_on", 1'b1, pll_enable)
    `CHK("pll_factor", 11'h004, pll_feedback_factor)
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("lock_cleared", 1'b0, rdat[2])
    repeat (80) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("locked", 1'b1, rdat[2])
    xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00040301);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("relock_wait", 1'b0, rdat[2])
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00040300 | k);
      meas(400);
      `CHK("ref_ticks", k == 0 ? 0 : 100 / k, near(k == 0 ? 0 : 100 / k, d_ref))
    end
    for (int u = 0; u < 4; u++) begin
      xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00040301 | (u << 28));
      repeat (100) @(posedge sys_clk);
      meas(480);
      `CHK("usb_ticks", u == 3 ? 0 : 80 >> u, near(u == 3 ? 0 : 80 >> u, d_usb))
    end
    xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00000301);
    `CHK("pll_off", 1'b0, pll_enable)
    xfer(1'b1, `CKPM_OFF_PLL_CFG, 32'h00040301);
    repeat (100) @(posedge sys_clk);
  endtask : t_pll

  // Master clock source and prescaler, then its ready flag.
  task automatic t_mck();
    int ex[4] = '{128, 512, 0, 341};
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, `CKPM_OFF_MCK_CFG, (p << 2) | 1);
      meas(2048);
      `CHK("mck_clock_scaler_ratio", p == 7 ? 0 : 512 >> p, near(p == 7 ? 0 : 512 >> p, d_mck))
    end
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `CKPM_OFF_MCK_CFG, s);
      meas(2048);
      `CHK("mck_source", ex[s], near(ex[s], d_mck))
    end
    xfer(1'b1, `CKPM_OFF_MCK_CFG, 32'h00000018);
    xfer(1'b1, `CKPM_OFF_IRQ_SET, 32'h00000008);
    @(posedge sys_clk);
    `CHK("irq_sticky", 1'b1, irq)
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("mck_not_ready", 1'b0, rdat[3])
    @(posedge sys_clk);
    `CHK("irq_read_clear", 1'b0, irq)
    repeat (1100) @(posedge sys_clk);
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("mck_ready", 1'b1, rdat[3])
  endtask : t_mck

  // Each programmable output divides the main clock by its own ratio.
  task automatic t_pck();
    for (int i = 0; i < 4; i++) xfer(1'b1, `CKPM_OFF_PCK0 + 8'(4 * i), (i << 2) | 1);
    meas(1024);
    for (int i = 0; i < 4; i++) `CHK("pck_ticks", 256 >> i, near(256 >> i, d_pck[i]))
    xfer(1'b0, `CKPM_OFF_STATUS, 32'h0);
    `CHK("pck_ready", 4'hf, rdat[11:8])
  endtask : t_pck

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Reset for five cycles, then run every scenario.
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_osc();
    t_pll();
    t_mck();
    t_pck();
    final_report();
  end
endmodule : ckpm_ctrl_tb
`default_nettype wire
